// file: common/isp_tap_pkg.sv
// Shared constants, opcodes and state types for the scan port and its controller
package isp_tap_pkg;

   // ---------------------------------------------------------------
   // Instruction register
   // ---------------------------------------------------------------
   localparam int           IR_W          = 4;
   localparam logic [3:0]   OP_EXTEST     = 4'h0;
   localparam logic [3:0]   OP_IDCODE     = 4'h1;
   localparam logic [3:0]   OP_INTEST     = 4'h2;
   localparam logic [3:0]   OP_PROG_ENTRY = 4'hA;
   localparam logic [3:0]   OP_PROG_EXIT  = 4'hB;
   localparam logic [3:0]   OP_BYPASS     = 4'hF;
   localparam logic [3:0]   CAPTURE_IR    = 4'h1;

   // ---------------------------------------------------------------
   // Data registers
   // ---------------------------------------------------------------
   localparam int           ID_W          = 32;
   // Value is arbitrary; bit 0 must stay one
   localparam logic [31:0]  IDCODE_DEF    = 32'h0A5C_3E11;
   localparam logic         BYPASS_CAP    = 1'h0;

   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam int           MCLK_MHZ      = 50;
   localparam int           EXIT_TIME_US  = 100;
   localparam int           EXIT_CYC_DEF  = EXIT_TIME_US * MCLK_MHZ;
   localparam int           TCK_DIV_DEF   = 8;
   localparam int           TLR_CYC       = 5;

   // ---------------------------------------------------------------
   // Controller commands
   // ---------------------------------------------------------------
   localparam logic [1:0]   CMD_RESET     = 2'h0;
   localparam logic [1:0]   CMD_IR        = 2'h1;
   localparam logic [1:0]   CMD_DR        = 2'h2;

   typedef enum logic [3:0] {
      TAP_TLR      = 4'h0, TAP_RTI      = 4'h1, TAP_SEL_DR   = 4'h3, TAP_CAP_DR   = 4'h2,
      TAP_SHIFT_DR = 4'h6, TAP_EXIT1_DR = 4'h7, TAP_PAUSE_DR = 4'h5, TAP_EXIT2_DR = 4'h4,
      TAP_UPD_DR   = 4'hC, TAP_SEL_IR   = 4'hD, TAP_CAP_IR   = 4'hF, TAP_SHIFT_IR = 4'hE,
      TAP_EXIT1_IR = 4'hA, TAP_PAUSE_IR = 4'hB, TAP_EXIT2_IR = 4'h9, TAP_UPD_IR   = 4'h8
   } tap_state_t;

   typedef enum logic [3:0] {
      H_IDLE  = 4'h0, H_SELDR = 4'h1, H_SELIR = 4'h3, H_CAPA = 4'h2,
      H_CAPB  = 4'h6, H_SHIFT = 4'h7, H_EXIT1 = 4'h5, H_DONE = 4'h4,
      H_TLR   = 4'hC
   } host_state_t;

endpackage

// file: common/jtag_if.sv
// Four-wire scan link between controller and device, with the TDO float resolved
`timescale 1ns/1ns
interface jtag_if;
   logic tck;
   logic tms;
   logic tdi;
   logic tdo;
   logic tdo_oe_n;
   logic tdo_line;

   // Floating TDO reads as one, as a pulled-up line would
   assign tdo_line = tdo_oe_n ? 1'h1 : tdo;

   modport dev  (input tck, input tms, input tdi, output tdo, output tdo_oe_n);
   modport host (output tck, output tms, output tdi, input tdo_line);
endinterface

// file: rtl/isp_tap_dev.sv
// Device end: scan port on the link clock, mission-mode pin control on mclk
`timescale 1ns/1ns
// Function
// [R1] Isolate mission logic during test and programming
// [R2] Program entry floats pins with pull-up at once
// [R3] In entry mode pins neither drive nor sense
// [R4] Pins stay floated while exit opcode loaded
// [R5] Displacing exit reinitialises pins and flip-flops
// [R6] Exit operation lasts about 100 microseconds
// [R7] Held exit defers mission return until displaced
// [R8] Controller issues entry before program-memory operations
// [R9] Controller closes each group with exit opcode
// [R10] Controller brackets test and programming with both
// [R11] Designer picks system-safe initial states
// [R12] Shift-IR shifts out the fixed capture pattern
// [R13] After reset IDCODE is the selected register
// [R14] First IDCODE bit shifted out is one
// [R15] TDO changes on falling TCK edge
// [R16] TDO floats outside Shift-IR and Shift-DR
// [R17] Last TDI bit goes with TMS high
// [R18] Bypass returns TDI one TCK later
// [R19] Exit ends on update of non-entry opcode
// [R20] Private opcodes decoded alongside standard ones
module isp_tap_dev #(
   parameter int          PINS     = 8,
   parameter int          EXIT_CYC = isp_tap_pkg::EXIT_CYC_DEF,
   parameter logic [31:0] IDCODE   = isp_tap_pkg::IDCODE_DEF
) (
   input  wire logic            mclk,
   input  wire logic            srst,
   jtag_if.dev                  jt,
   input  wire logic [PINS-1:0] core_out,
   input  wire logic [PINS-1:0] core_oe_n,
   output logic      [PINS-1:0] core_in,
   input  wire logic [PINS-1:0] pin_in,
   output logic      [PINS-1:0] pin_out,
   output logic      [PINS-1:0] pin_oe_n,
   output logic                 pullup_en,
   output logic                 mission_en,
   output logic                 reinit
);
   localparam int IW = isp_tap_pkg::IR_W;
   localparam int CW = $clog2(EXIT_CYC + 1);
   localparam int SW = PINS + 3;
   localparam logic [CW-1:0] EXIT_LAST = CW'(EXIT_CYC - 1);

   // ---------------------------------------------------------------
   // TAP state step
   // ---------------------------------------------------------------
   function automatic isp_tap_pkg::tap_state_t tap_next(input isp_tap_pkg::tap_state_t s, input logic m);
      case (s)
         isp_tap_pkg::TAP_TLR:      tap_next = m ? isp_tap_pkg::TAP_TLR      : isp_tap_pkg::TAP_RTI;
         isp_tap_pkg::TAP_RTI:      tap_next = m ? isp_tap_pkg::TAP_SEL_DR   : isp_tap_pkg::TAP_RTI;
         isp_tap_pkg::TAP_SEL_DR:   tap_next = m ? isp_tap_pkg::TAP_SEL_IR   : isp_tap_pkg::TAP_CAP_DR;
         isp_tap_pkg::TAP_CAP_DR:   tap_next = m ? isp_tap_pkg::TAP_EXIT1_DR : isp_tap_pkg::TAP_SHIFT_DR;
         isp_tap_pkg::TAP_SHIFT_DR: tap_next = m ? isp_tap_pkg::TAP_EXIT1_DR : isp_tap_pkg::TAP_SHIFT_DR;
         isp_tap_pkg::TAP_EXIT1_DR: tap_next = m ? isp_tap_pkg::TAP_UPD_DR   : isp_tap_pkg::TAP_PAUSE_DR;
         isp_tap_pkg::TAP_PAUSE_DR: tap_next = m ? isp_tap_pkg::TAP_EXIT2_DR : isp_tap_pkg::TAP_PAUSE_DR;
         isp_tap_pkg::TAP_EXIT2_DR: tap_next = m ? isp_tap_pkg::TAP_UPD_DR   : isp_tap_pkg::TAP_SHIFT_DR;
         isp_tap_pkg::TAP_UPD_DR:   tap_next = m ? isp_tap_pkg::TAP_SEL_DR   : isp_tap_pkg::TAP_RTI;
         isp_tap_pkg::TAP_SEL_IR:   tap_next = m ? isp_tap_pkg::TAP_TLR      : isp_tap_pkg::TAP_CAP_IR;
         isp_tap_pkg::TAP_CAP_IR:   tap_next = m ? isp_tap_pkg::TAP_EXIT1_IR : isp_tap_pkg::TAP_SHIFT_IR;
         isp_tap_pkg::TAP_SHIFT_IR: tap_next = m ? isp_tap_pkg::TAP_EXIT1_IR : isp_tap_pkg::TAP_SHIFT_IR;
         isp_tap_pkg::TAP_EXIT1_IR: tap_next = m ? isp_tap_pkg::TAP_UPD_IR   : isp_tap_pkg::TAP_PAUSE_IR;
         isp_tap_pkg::TAP_PAUSE_IR: tap_next = m ? isp_tap_pkg::TAP_EXIT2_IR : isp_tap_pkg::TAP_PAUSE_IR;
         isp_tap_pkg::TAP_EXIT2_IR: tap_next = m ? isp_tap_pkg::TAP_UPD_IR   : isp_tap_pkg::TAP_SHIFT_IR;
         isp_tap_pkg::TAP_UPD_IR:   tap_next = m ? isp_tap_pkg::TAP_SEL_DR   : isp_tap_pkg::TAP_RTI;
         default:                   tap_next = isp_tap_pkg::TAP_TLR;
      endcase
   endfunction

   // ---------------------------------------------------------------
   // Link clock domain
   // ---------------------------------------------------------------
   logic [2:0]             trst_sync_ff;
   logic                   tap_rst_ff;
   isp_tap_pkg::tap_state_t tap_ff;
   logic [IW-1:0]          ir_ff;
   logic [IW-1:0]          ir_sh_ff;
   logic [31:0]            id_sh_ff;
   logic                   byp_ff;
   logic                   isp_ff;
   logic                   iso_ff;
   logic                   exit_lv_ff;
   logic                   reinit_tgl_ff;
   logic                   tdo_ff;
   logic                   tdo_oe_n_ff;
   logic                   displace;

   // Reset reaches the link domain only while TCK runs; the controller keeps TCK free-running
   always_ff @(posedge jt.tck) begin
      trst_sync_ff <= {trst_sync_ff[1:0], srst};
      if (trst_sync_ff[1] == trst_sync_ff[2]) begin
         tap_rst_ff <= trst_sync_ff[2];
      end
   end

   always_ff @(posedge jt.tck) begin
      if (tap_rst_ff) begin
         tap_ff <= isp_tap_pkg::TAP_TLR;
      end else begin
         tap_ff <= tap_next(tap_ff, jt.tms);
      end
   end

   always_ff @(posedge jt.tck) begin
      if (tap_rst_ff || tap_ff == isp_tap_pkg::TAP_TLR) begin
         ir_ff    <= isp_tap_pkg::OP_IDCODE; // [R13]
         ir_sh_ff <= isp_tap_pkg::CAPTURE_IR;
      end else if (tap_ff == isp_tap_pkg::TAP_CAP_IR) begin
         ir_sh_ff <= isp_tap_pkg::CAPTURE_IR; // [R12]
      end else if (tap_ff == isp_tap_pkg::TAP_SHIFT_IR) begin
         ir_sh_ff <= {jt.tdi, ir_sh_ff[IW-1:1]};
      end else if (tap_ff == isp_tap_pkg::TAP_UPD_IR) begin
         ir_ff <= ir_sh_ff;
      end
   end

   always_ff @(posedge jt.tck) begin
      if (tap_rst_ff) begin
         id_sh_ff <= IDCODE;
         byp_ff   <= isp_tap_pkg::BYPASS_CAP;
      end else if (tap_ff == isp_tap_pkg::TAP_CAP_DR) begin
         id_sh_ff <= IDCODE; // [R14]
         byp_ff   <= isp_tap_pkg::BYPASS_CAP;
      end else if (tap_ff == isp_tap_pkg::TAP_SHIFT_DR) begin
         id_sh_ff <= {jt.tdi, id_sh_ff[31:1]};
         byp_ff   <= jt.tdi; // [R18]
      end
   end

   // A new opcode other than the two private ones, or a TAP reset, displaces the exit opcode
   assign displace = (tap_ff == isp_tap_pkg::TAP_UPD_IR && ir_sh_ff != isp_tap_pkg::OP_PROG_ENTRY
                      && ir_sh_ff != isp_tap_pkg::OP_PROG_EXIT) || tap_ff == isp_tap_pkg::TAP_TLR; // [R19]

   always_ff @(posedge jt.tck) begin
      if (tap_rst_ff) begin
         isp_ff        <= 1'h0;
         reinit_tgl_ff <= 1'h0;
      end else if (tap_ff == isp_tap_pkg::TAP_UPD_IR && ir_sh_ff == isp_tap_pkg::OP_PROG_ENTRY) begin
         isp_ff <= 1'h1; // [R2] [R20]
      end else if (isp_ff && ir_ff == isp_tap_pkg::OP_PROG_EXIT && displace) begin
         isp_ff        <= 1'h0; // [R5]
         reinit_tgl_ff <= ~reinit_tgl_ff;
      end
   end

   // Registered so the crossing sees single flops, not a decode that may glitch
   always_ff @(posedge jt.tck) begin
      if (tap_rst_ff) begin
         iso_ff     <= 1'h0;
         exit_lv_ff <= 1'h0;
      end else begin
         iso_ff     <= isp_ff || ir_ff == isp_tap_pkg::OP_EXTEST || ir_ff == isp_tap_pkg::OP_INTEST; // [R1]
         exit_lv_ff <= ir_ff == isp_tap_pkg::OP_PROG_EXIT; // [R4]
      end
   end

   always_ff @(negedge jt.tck) begin
      if (tap_rst_ff) begin
         tdo_ff      <= 1'h0;
         tdo_oe_n_ff <= 1'h1;
      end else begin
         tdo_oe_n_ff <= !(tap_ff == isp_tap_pkg::TAP_SHIFT_IR || tap_ff == isp_tap_pkg::TAP_SHIFT_DR); // [R16]
         if (tap_ff == isp_tap_pkg::TAP_SHIFT_IR) begin
            tdo_ff <= ir_sh_ff[0]; // [R15]
         end else if (ir_ff == isp_tap_pkg::OP_IDCODE) begin
            tdo_ff <= id_sh_ff[0];
         end else begin
            tdo_ff <= byp_ff;
         end
      end
   end

   assign jt.tdo      = tdo_ff;
   assign jt.tdo_oe_n = tdo_oe_n_ff;

   // ---------------------------------------------------------------
   // System clock domain
   // ---------------------------------------------------------------
   logic [SW-1:0] s1_ff;
   logic [SW-1:0] s2_ff;
   logic [SW-1:0] s3_ff;
   logic [SW-1:0] lvl_ff;
   logic          tgl_d_ff;
   logic          tgl_ev;
   logic          pend_ff;
   logic [CW-1:0] cnt_ff;
   logic          done_ff;
   logic          nxt_mission;
   logic [PINS-1:0] pin_s;

   // A bit changes only once the second and third stages agree
   always_ff @(posedge mclk) begin
      s1_ff  <= {pin_in, iso_ff, exit_lv_ff, reinit_tgl_ff};
      s2_ff  <= s1_ff;
      s3_ff  <= s2_ff;
      if (srst) begin
         lvl_ff <= '0;
      end else begin
         lvl_ff <= (~(s2_ff ^ s3_ff) & s3_ff) | ((s2_ff ^ s3_ff) & lvl_ff);
      end
   end

   assign pin_s  = lvl_ff[SW-1:3];
   assign tgl_ev = lvl_ff[0] ^ tgl_d_ff;

   always_ff @(posedge mclk) begin
      if (srst) begin
         tgl_d_ff <= 1'h0;
      end else begin
         tgl_d_ff <= lvl_ff[0];
      end
   end

   // Exit timer runs while the exit opcode is loaded or its displacement waits;
   // any idle spell clears it, so every fresh exit load times the full operation
   always_ff @(posedge mclk) begin
      if (srst || reinit || !(lvl_ff[1] || pend_ff)) begin
         cnt_ff  <= '0;
         done_ff <= 1'h0;
      end else if (!done_ff) begin
         if (cnt_ff == EXIT_LAST) begin
            done_ff <= 1'h1; // [R6]
         end else begin
            cnt_ff <= cnt_ff + CW'(1);
         end
      end
   end

   // The displacement event sets over the clear
   always_ff @(posedge mclk) begin
      if (srst) begin
         pend_ff <= 1'h0;
      end else if (tgl_ev) begin
         pend_ff <= 1'h1; // [R7]
      end else if (pend_ff && done_ff) begin
         pend_ff <= 1'h0;
      end
   end

   assign nxt_mission = !(lvl_ff[2] || pend_ff || tgl_ev); // [R1] [R4] [R7]

   always_ff @(posedge mclk) begin
      if (srst) begin
         reinit     <= 1'h0;
         mission_en <= 1'h0;
      end else begin
         reinit     <= pend_ff && done_ff && !tgl_ev; // [R5] [R11]
         mission_en <= nxt_mission;
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         pin_out   <= '0;
         pin_oe_n  <= '1;
         pullup_en <= 1'h1;
         core_in   <= '0;
      end else begin
         pin_out   <= nxt_mission ? core_out : '0;  // [R3]
         pin_oe_n  <= nxt_mission ? core_oe_n : '1; // [R2]
         pullup_en <= !nxt_mission;
         core_in   <= nxt_mission ? pin_s : '0;     // [R3]
      end
   end

endmodule // isp_tap_dev

// file: rtl/isp_tap_host.sv
// Controller end: divides mclk into TCK and walks the TAP for reset, IR and DR scans
`timescale 1ns/1ns
module isp_tap_host #(
   parameter int DIV = isp_tap_pkg::TCK_DIV_DEF
) (
   input  wire logic        mclk,
   input  wire logic        srst,
   jtag_if.host             jt,
   input  wire logic        cmd_valid,
   output logic             cmd_ready,
   input  wire logic [1:0]  cmd_op,
   input  wire logic [5:0]  cmd_len,
   input  wire logic [31:0] cmd_data,
   output logic             rsp_valid,
   output logic [31:0]      rsp_data
);
   localparam int PW = $clog2(DIV);
   localparam logic [PW-1:0] PH_LAST = PW'(DIV - 1);
   localparam logic [PW-1:0] PH_HALF = PW'(DIV / 2);
   localparam logic [2:0]    TLR_LAST = 3'(isp_tap_pkg::TLR_CYC - 1);

   logic [PW-1:0]           phase_ff;
   logic                    tck_ff;
   logic                    tms_ff;
   logic                    tdi_ff;
   logic                    step;
   isp_tap_pkg::host_state_t st_ff;
   logic                    pend_ff;
   logic [1:0]              op_ff;
   logic [5:0]              len_ff;
   logic [31:0]             data_ff;
   logic [31:0]             cap_ff;
   logic [4:0]              bit_ff;
   logic [2:0]              tlr_ff;
   logic [2:0]              tdo_sync_ff;
   logic                    tdo_s_ff;
   logic                    take;
   logic                    rst_seen_ff;

   // ---------------------------------------------------------------
   // TCK divider: state moves on the falling edge, device samples on the rising one
   // ---------------------------------------------------------------
   assign step = phase_ff == PH_LAST;

   always_ff @(posedge mclk) begin
      rst_seen_ff <= srst;
   end

   // Restarts only on the first reset cycle, so TCK keeps running while reset is held
   always_ff @(posedge mclk) begin
      if (!srst || rst_seen_ff) begin
         phase_ff <= step ? '0 : phase_ff + PW'(1);
         tck_ff   <= !step && (phase_ff + PW'(1)) >= PH_HALF;
      end else begin
         phase_ff <= '0;
         tck_ff   <= 1'h0;
      end
   end

   // TDO is sampled late in each TCK period, so DIV below 5 leaves too little settling time
   always_ff @(posedge mclk) begin
      tdo_sync_ff <= {tdo_sync_ff[1:0], jt.tdo_line};
      if (srst) begin
         tdo_s_ff <= 1'h1;
      end else if (tdo_sync_ff[1] == tdo_sync_ff[2]) begin
         tdo_s_ff <= tdo_sync_ff[2];
      end
   end

   // ---------------------------------------------------------------
   // Command intake
   // ---------------------------------------------------------------
   assign take = step && st_ff == isp_tap_pkg::H_IDLE && pend_ff;

   always_ff @(posedge mclk) begin
      if (srst) begin
         pend_ff   <= 1'h0;
         cmd_ready <= 1'h0;
         op_ff     <= isp_tap_pkg::CMD_RESET;
         len_ff    <= '0;
      end else if (cmd_valid && cmd_ready) begin
         pend_ff   <= 1'h1;
         cmd_ready <= 1'h0;
         op_ff     <= cmd_op;
         len_ff    <= (cmd_len == 6'h00) ? 6'h01 : cmd_len;
      end else begin
         if (take) begin
            pend_ff <= 1'h0;
         end
         cmd_ready <= !pend_ff && st_ff == isp_tap_pkg::H_IDLE && !step;
      end
   end

   // ---------------------------------------------------------------
   // Sequencer
   // ---------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (srst) begin
         st_ff     <= isp_tap_pkg::H_IDLE;
         tms_ff    <= 1'h0;
         tdi_ff    <= 1'h1;
         bit_ff    <= '0;
         tlr_ff    <= '0;
         data_ff   <= '0;
         cap_ff    <= '0;
         rsp_valid <= 1'h0;
         rsp_data  <= '0;
      end else begin
         rsp_valid <= 1'h0;
         if (cmd_valid && cmd_ready) begin
            data_ff <= cmd_data;
         end
         if (step) begin
            case (st_ff)
               isp_tap_pkg::H_IDLE: begin
                  tms_ff <= 1'h0;
                  if (pend_ff) begin
                     st_ff  <= (op_ff == isp_tap_pkg::CMD_RESET) ? isp_tap_pkg::H_TLR : isp_tap_pkg::H_SELDR;
                     tms_ff <= 1'h1;
                     tlr_ff <= '0;
                  end
               end
               isp_tap_pkg::H_TLR: begin
                  if (tlr_ff == TLR_LAST) begin
                     st_ff  <= isp_tap_pkg::H_DONE;
                     tms_ff <= 1'h0;
                  end else begin
                     tlr_ff <= tlr_ff + 3'h1;
                  end
               end
               isp_tap_pkg::H_SELDR: begin
                  // IR loads carry the opcodes that bracket test and programming groups
                  st_ff  <= (op_ff == isp_tap_pkg::CMD_IR) ? isp_tap_pkg::H_SELIR : isp_tap_pkg::H_CAPA; // [R8] [R9] [R10]
                  tms_ff <= op_ff == isp_tap_pkg::CMD_IR;
               end
               isp_tap_pkg::H_SELIR: begin
                  st_ff  <= isp_tap_pkg::H_CAPA;
                  tms_ff <= 1'h0;
               end
               isp_tap_pkg::H_CAPA: begin
                  st_ff  <= isp_tap_pkg::H_CAPB;
                  tms_ff <= 1'h0;
               end
               isp_tap_pkg::H_CAPB: begin
                  st_ff   <= isp_tap_pkg::H_SHIFT;
                  bit_ff  <= '0;
                  tdi_ff  <= data_ff[0];
                  data_ff <= {1'h0, data_ff[31:1]};
                  tms_ff  <= len_ff == 6'h01; // [R17]
               end
               isp_tap_pkg::H_SHIFT: begin
                  cap_ff[bit_ff] <= tdo_s_ff;
                  if ({1'h0, bit_ff} == len_ff - 6'h01) begin
                     st_ff  <= isp_tap_pkg::H_EXIT1;
                     tms_ff <= 1'h1;
                  end else begin
                     bit_ff  <= bit_ff + 5'h01;
                     tdi_ff  <= data_ff[0];
                     data_ff <= {1'h0, data_ff[31:1]};
                     tms_ff  <= {1'h0, bit_ff} + 6'h02 == len_ff; // [R17]
                  end
               end
               isp_tap_pkg::H_EXIT1: begin
                  st_ff  <= isp_tap_pkg::H_DONE;
                  tms_ff <= 1'h0;
                  tdi_ff <= 1'h1;
               end
               isp_tap_pkg::H_DONE: begin
                  st_ff     <= isp_tap_pkg::H_IDLE;
                  tms_ff    <= 1'h0;
                  rsp_valid <= 1'h1;
                  rsp_data  <= cap_ff;
                  cap_ff    <= '0;
               end
               default: begin
                  st_ff  <= isp_tap_pkg::H_IDLE;
                  tms_ff <= 1'h0;
               end
            endcase
         end
      end
   end

   assign jt.tck = tck_ff;
   assign jt.tms = tms_ff;
   assign jt.tdi = tdi_ff;

endmodule // isp_tap_host

// file: tb/isp_tap_checker.sv
// Concurrent checks on the scan link between controller and device
`timescale 1ns/1ns
module isp_tap_checker #(
   parameter logic [31:0] IDCODE = isp_tap_pkg::IDCODE_DEF
) (
   input wire logic mclk,
   input wire logic srst,
   input wire logic tck,
   input wire logic tms,
   input wire logic tdi,
   input wire logic tdo,
   input wire logic tdo_oe_n
);
   // ---------------------------------------------------------------
   // Shadow TAP, stepped on the same edges as the device
   // ---------------------------------------------------------------
   // Successor state per state code, one nibble each, for tms low and high
   localparam logic [63:0] STEP_LO = 64'hEEF1_BBE1_5656_2611;
   localparam logic [63:0] STEP_HI = 64'hAA03_9883_C74C_D730;
   logic [3:0] st_ff;
   logic [3:0] ir_ff;
   logic [3:0] irs_ff;
   logic [5:0] cnt_ff;
   logic       shf;
   logic       byp;
   assign shf = st_ff == isp_tap_pkg::TAP_SHIFT_IR || st_ff == isp_tap_pkg::TAP_SHIFT_DR;
   assign byp = st_ff == isp_tap_pkg::TAP_SHIFT_DR && ir_ff != isp_tap_pkg::OP_IDCODE;
   always_ff @(posedge tck) begin
      if (srst) st_ff <= 4'h0;
      else st_ff <= tms ? STEP_HI[st_ff*4 +: 4] : STEP_LO[st_ff*4 +: 4];
   end
   always_ff @(posedge tck) begin
      cnt_ff <= shf ? cnt_ff + 6'h1 : 6'h0;
      if (st_ff == isp_tap_pkg::TAP_SHIFT_IR) irs_ff <= {tdi, irs_ff[3:1]};
   end
   always_ff @(posedge tck) begin
      if (srst || st_ff == isp_tap_pkg::TAP_TLR) ir_ff <= isp_tap_pkg::OP_IDCODE;
      else if (st_ff == isp_tap_pkg::TAP_UPD_IR) ir_ff <= irs_ff;
   end
   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   AST_TDO_DRIVE: assert property (@(posedge tck) disable iff (srst) shf |-> !tdo_oe_n)
      else $error("tdo not driven while shifting");
   AST_TDO_FLOAT: assert property (@(posedge tck) disable iff (srst) !shf |-> tdo_oe_n)
      else $error("tdo driven outside shift");
   AST_CAPTURE_IR: assert property (@(posedge tck) disable iff (srst)
      st_ff == isp_tap_pkg::TAP_SHIFT_IR && cnt_ff < 6'h4 |-> tdo == isp_tap_pkg::CAPTURE_IR[cnt_ff[1:0]])
      else $error("wrong capture pattern bit");
   AST_IDCODE: assert property (@(posedge tck) disable iff (srst)
      st_ff == isp_tap_pkg::TAP_SHIFT_DR && !byp |-> tdo == IDCODE[cnt_ff[4:0]])
      else $error("wrong identity bit");
   AST_BYPASS_CAP: assert property (@(posedge tck) disable iff (srst) byp && cnt_ff == 6'h0 |-> !tdo)
      else $error("bypass first bit not zero");
   AST_BYPASS_DELAY: assert property (@(posedge tck) disable iff (srst) byp && cnt_ff != 6'h0 |-> tdo == $past(tdi))
      else $error("bypass does not delay tdi by one tck");
   AST_TDO_FALL: assert property (@(posedge mclk) disable iff (srst) $changed(tdo) |-> $fell(tck))
      else $error("tdo changed off the falling tck edge");
   AST_OE_FALL: assert property (@(posedge mclk) disable iff (srst) $changed(tdo_oe_n) |-> $fell(tck))
      else $error("tdo enable changed off the falling tck edge");
   cover property (@(posedge tck) disable iff (srst) st_ff == isp_tap_pkg::TAP_SHIFT_IR && cnt_ff == 6'h3);
   cover property (@(posedge tck) disable iff (srst) !byp && cnt_ff == 6'h1F);
   cover property (@(posedge tck) disable iff (srst) byp && cnt_ff == 6'h7);
endmodule // isp_tap_checker

// file: tb/jtag_isp_mission_mode_control_test.sv
// Self-checking bench: controller and device joined over the scan link
`timescale 1ns/1ns
module jtag_isp_mission_mode_control_test;
   // Short exit time keeps the run brief; still longer than one IR scan
   localparam int EXIT_CYC = 400;
   logic        mclk, srst, cmd_valid, cmd_ready, rsp_valid, pullup_en, mission_en, reinit;
   logic [1:0]  cmd_op;
   logic [5:0]  cmd_len;
   logic [31:0] cmd_data, rsp_data;
   logic [7:0]  core_out, core_oe_n, core_in, pin_in, pin_out, pin_oe_n;
   int          err_total = 0, check_count = 0, reinit_cnt = 0, cyc = 0, reinit_cyc = 0, t0;
   jtag_if jt();
   isp_tap_host u_isp_tap_host (.mclk(mclk), .srst(srst), .jt(jt), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
      .cmd_op(cmd_op), .cmd_len(cmd_len), .cmd_data(cmd_data), .rsp_valid(rsp_valid), .rsp_data(rsp_data));
   isp_tap_dev #(.EXIT_CYC(EXIT_CYC)) u_isp_tap_dev (.mclk(mclk), .srst(srst), .jt(jt), .core_out(core_out),
      .core_oe_n(core_oe_n), .core_in(core_in), .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
      .pullup_en(pullup_en), .mission_en(mission_en), .reinit(reinit));
   isp_tap_checker u_isp_tap_checker (.mclk(mclk), .srst(srst), .tck(jt.tck), .tms(jt.tms), .tdi(jt.tdi),
      .tdo(jt.tdo), .tdo_oe_n(jt.tdo_oe_n));
   initial begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (reinit === 1'b1) begin
         reinit_cnt <= reinit_cnt + 1;
         reinit_cyc <= cyc;
      end
   end
   task automatic test_done();
      if (err_total == 0 && check_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         err_total++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // Holds the command until taken, then waits for the answer; a hang counts as a mismatch
   task automatic scan(input logic [1:0] op, input logic [5:0] len, input logic [31:0] data);
      int n;
      n = 0;
      @(posedge mclk);
      {cmd_valid, cmd_op, cmd_len, cmd_data} <= {1'b1, op, len, data};
      do @(posedge mclk); while (cmd_ready !== 1'b1 && ++n < 3000);
      cmd_valid <= 1'b0;
      do @(posedge mclk); while (rsp_valid !== 1'b1 && ++n < 3000);
      if (n >= 3000) chk(32'h1, 32'h0);
   endtask
   task automatic ir(input logic [3:0] op);
      scan(isp_tap_pkg::CMD_IR, 6'h4, {28'h0, op});
      chk(rsp_data, {28'h0, isp_tap_pkg::CAPTURE_IR});
   endtask
   // Isolated: floated with pull-ups, nothing driven or sensed; else pins follow the core
   task automatic pins(input logic iso);
      repeat (16) @(posedge mclk);
      chk({mission_en, pullup_en, pin_oe_n, pin_out, core_in}, iso ? 26'h1FF_0000 : {2'h2, core_oe_n, core_out, pin_in});
   endtask
   initial begin
      #300us;
      err_total++;
      test_done();
   end
   initial begin
      {srst, cmd_valid, cmd_op, cmd_len, cmd_data} = {1'b1, 41'h0};
      {core_out, core_oe_n, pin_in} = 24'hC3_0F96;
      // Eight link clock periods, so the device's own reset copy lands
      repeat (64) @(posedge mclk);
      srst <= 1'b0;
      scan(isp_tap_pkg::CMD_RESET, 6'h1, 32'h0);
      repeat (64) @(posedge mclk);
      scan(isp_tap_pkg::CMD_DR, 6'h20, 32'h0);
      chk(rsp_data, isp_tap_pkg::IDCODE_DEF);
      pins(1'b0);
      ir(isp_tap_pkg::OP_BYPASS);
      scan(isp_tap_pkg::CMD_DR, 6'h8, 32'h5A);
      chk(rsp_data, 32'hB4);
      ir(isp_tap_pkg::OP_EXTEST);
      pins(1'b1);
      ir(isp_tap_pkg::OP_PROG_ENTRY);
      pins(1'b1);
      ir(isp_tap_pkg::OP_PROG_EXIT);
      ir(isp_tap_pkg::OP_PROG_ENTRY);
      pins(1'b1);
      ir(isp_tap_pkg::OP_PROG_EXIT);
      repeat (EXIT_CYC + 200) @(posedge mclk);
      pins(1'b1);
      chk(reinit_cnt, 32'h0);
      ir(isp_tap_pkg::OP_BYPASS);
      repeat (32) @(posedge mclk);
      chk(reinit_cnt, 32'h1);
      pins(1'b0);
      ir(isp_tap_pkg::OP_PROG_ENTRY);
      ir(isp_tap_pkg::OP_PROG_EXIT);
      t0 = cyc;
      ir(isp_tap_pkg::OP_IDCODE);
      chk(reinit_cnt, 32'h1);
      pins(1'b1);
      repeat (EXIT_CYC) @(posedge mclk);
      chk(reinit_cnt, 32'h2);
      chk({31'h0, reinit_cyc - t0 > EXIT_CYC - 40 && reinit_cyc - t0 < EXIT_CYC + 40}, 32'h1);
      pins(1'b0);
      test_done();
   end
endmodule // jtag_isp_mission_mode_control_test
